/* File: rtl/irq_code_pkg.sv */
// Package: register map, field layout and codes of the interrupt code block
package irq_code_pkg;
    localparam int unsigned FIFO_COUNT = 32;
    localparam int unsigned CODE_W = 7;
    localparam int unsigned FILT_W = 5;
    localparam int unsigned ADDR_W = 4;
    // Register word offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_MASK = 4'h8;
    // Field positions in the code register
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned FILT_LSB = 8;
    // Source codes
    localparam logic [CODE_W-1:0] CODE_NONE = 7'h40;
    localparam logic [CODE_W-1:0] CODE_BUS_ERR = 7'h41;
    localparam logic [CODE_W-1:0] CODE_WAKEUP = 7'h42;
    localparam logic [CODE_W-1:0] CODE_RX_OVF = 7'h43;
    localparam logic [CODE_W-1:0] CODE_ADDR_ERR = 7'h44;
    localparam logic [CODE_W-1:0] CODE_BW_ERR = 7'h45;
    localparam logic [CODE_W-1:0] CODE_TIMER = 7'h46;
    localparam logic [CODE_W-1:0] CODE_MODE = 7'h47;
    localparam logic [CODE_W-1:0] CODE_INVALID = 7'h48;
    localparam logic [FILT_W-1:0] FILT_RESET = 5'h00;
    // Interrupt status bits: code changed, filter hit updated
    localparam int unsigned EVT_W = 2;
    localparam int unsigned EVT_CODE = 0;
    localparam int unsigned EVT_FILT = 1;
    localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;

    // Module-level event flags
    typedef struct packed {
        logic invalid_message_flag;
        logic mode_change_flag;
        logic timestamp_timer_flag;
        logic bw_error_flag;
        logic addr_error_flag;
        logic rx_overflow_flag;
        logic wakeup_flag;
        logic bus_error_flag;
    } module_flags_t;

    // Register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

/* File: rtl/irq_priority_encoder.sv */
// Fixed-priority encoder from enabled pending sources to a source code
`timescale 1ns/1ns
module irq_priority_encoder
    import irq_code_pkg::*;
#(
    parameter int unsigned FIFOS = FIFO_COUNT
) (
    input wire logic [FIFOS-1:0] fifo_active,
    input wire module_flags_t mod_active,
    output logic [CODE_W-1:0] source_code
);
    always_comb begin
        source_code = CODE_NONE;
        if (mod_active.invalid_message_flag) begin
            source_code = CODE_INVALID;
        end
        if (mod_active.mode_change_flag) begin
            source_code = CODE_MODE;
        end
        if (mod_active.timestamp_timer_flag) begin
            source_code = CODE_TIMER;
        end
        if (mod_active.bw_error_flag) begin
            source_code = CODE_BW_ERR;
        end
        if (mod_active.addr_error_flag) begin
            source_code = CODE_ADDR_ERR;
        end
        if (mod_active.rx_overflow_flag) begin
            source_code = CODE_RX_OVF;
        end
        if (mod_active.wakeup_flag) begin
            source_code = CODE_WAKEUP;
        end
        if (mod_active.bus_error_flag) begin
            source_code = CODE_BUS_ERR;
        end
        for (int i = FIFOS - 1; i >= 0; i--) begin
            if (fifo_active[i]) begin
                source_code = CODE_W'(i);
            end
        end
    end
endmodule

/* File: rtl/can_interrupt_code_encoder.sv */
// Interrupt code register: reported source and matched filter
`timescale 1ns/1ns

module can_interrupt_code_encoder
    import irq_code_pkg::*;
#(
    parameter int unsigned FIFOS = FIFO_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    input wire logic [FIFOS-1:0] fifo_pending_status,
    input wire logic [FIFOS-1:0] fifo_irq_enable,
    input wire module_flags_t mod_flags,
    input wire module_flags_t mod_enable,
    input wire logic filter_hit_valid,
    input wire logic [FILT_W-1:0] filter_hit_index,
    output logic [CODE_W-1:0] interrupt_source_code,
    output logic [FILT_W-1:0] matched_filter_index,
    output logic irq
);
    logic [FIFOS-1:0] fifo_active;
    module_flags_t mod_active;
    logic [CODE_W-1:0] enc_code;
    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;
    logic [FILT_W-1:0] filt_r;
    logic [FILT_W-1:0] filt_nxt;
    logic [EVT_W-1:0] status_r;
    logic [EVT_W-1:0] status_nxt;
    logic [EVT_W-1:0] mask_r;
    logic [EVT_W-1:0] mask_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [EVT_W-1:0] events;

    // Gate each flag with its enable
    assign fifo_active = fifo_pending_status & fifo_irq_enable;
    assign mod_active = mod_flags & mod_enable;

    irq_priority_encoder #(
        .FIFOS(FIFOS)
    ) u_enc (
        .fifo_active(fifo_active),
        .mod_active(mod_active),
        .source_code(enc_code)
    );

    function automatic logic [31:0] code_word(
        input logic [CODE_W-1:0] c,
        input logic [FILT_W-1:0] f
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CODE_LSB +: CODE_W] = c;
        w[FILT_LSB +: FILT_W] = f;
        return w;
    endfunction

    always_comb begin
        // Encoder only yields 0x00-0x1F or 0x40-0x48
        code_nxt = enc_code;
        filt_nxt = filt_r;
        if (filter_hit_valid) begin
            filt_nxt = filter_hit_index;
        end
        events = '0;
        events[EVT_CODE] = (code_nxt != code_r);
        events[EVT_FILT] = filter_hit_valid;
        mask_nxt = mask_r;
        status_nxt = status_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFF_CODE: rdata_nxt = code_word(code_r, filt_r);
                OFF_STATUS: begin
                    rdata_nxt[EVT_W-1:0] = status_r;
                    status_nxt = '0;
                end
                OFF_MASK: rdata_nxt[EVT_W-1:0] = mask_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // Set wins over read-clear
        status_nxt = status_nxt | events;
        if (reg_req.wr && reg_req.addr == OFF_MASK) begin
            mask_nxt = reg_req.wdata[EVT_W-1:0];
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            code_r <= CODE_NONE;
            filt_r <= FILT_RESET;
            status_r <= '0;
            mask_r <= MASK_RESET;
            rdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end else begin
            code_r <= code_nxt;
            filt_r <= filt_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign interrupt_source_code = code_r;
    assign matched_filter_index = filt_r;
    assign irq = irq_r;
endmodule

/* File: verification/irq_code_chk.sv */
// Port checker for the interrupt code encoder
`timescale 1ns/1ns
module irq_code_chk
    import irq_code_pkg::*;
#(
    parameter int unsigned FIFOS = FIFO_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic [FIFOS-1:0] fifo_pending_status,
    input wire logic [FIFOS-1:0] fifo_irq_enable,
    input wire module_flags_t mod_flags,
    input wire module_flags_t mod_enable,
    input wire logic filter_hit_valid,
    input wire logic [FILT_W-1:0] filter_hit_index,
    input wire logic [CODE_W-1:0] interrupt_source_code,
    input wire logic [FILT_W-1:0] matched_filter_index,
    input wire logic irq
);
wire [FIFOS-1:0] fa = fifo_pending_status & fifo_irq_enable;
wire [7:0] ma = mod_flags & mod_enable;
wire [6:0] c = interrupt_source_code;
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
sequence s_hit; filter_hit_valid; endsequence
sequence s_quiet; $stable(fa) && $stable(ma) && $past(rst_n); endsequence
property p_filt; s_hit |=> matched_filter_index == $past(filter_hit_index);
endproperty
a_filt: assert property (p_filt) else $error("filter index");
property p_fifo0; fa[0] |=> c == 7'h00; endproperty
a_fifo0: assert property (p_fifo0) else $error("fifo code");
property p_none; !(|fa) && !(|ma) |=> c == CODE_NONE; endproperty
a_none: assert property (p_none) else $error("idle code");
property p_legal; c < 7'h20 || (c >= CODE_NONE && c <= CODE_INVALID);
endproperty
a_legal: assert property (p_legal) else $error("reserved code");
property p_bus; !(|fa) && ma[0] |=> c == CODE_BUS_ERR; endproperty
a_bus: assert property (p_bus) else $error("bus error code");
property p_inv; !(|fa) && ma == 8'h80 |=> c == CODE_INVALID; endproperty
a_inv: assert property (p_inv) else $error("invalid code");
property p_hold; s_quiet |=> $stable(c); endproperty
a_hold: assert property (p_hold) else $error("code moved");
property p_rd; !reg_req.rd |=> reg_rdata == 32'h0; endproperty
a_rd: assert property (p_rd) else $error("read data");
endmodule

/* File: verification/can_interrupt_code_encoder_tb_top.sv */
// Bench for the interrupt code encoder
`timescale 1ns/1ns
module can_interrupt_code_encoder_tb_top
    import irq_code_pkg::*;
;
logic sys_clk = 1'h0, rst_n = 1'h0, hv = 1'h0, irq;
logic [4:0] hi = 5'h0, filt;
logic [6:0] code;
logic [31:0] rdata, d, fp = '0, fe = '0;
module_flags_t mf = '0, me = '0;
reg_req_t req = '0;
int n_mismatch = 0, n_tests = 0;
can_interrupt_code_encoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .fifo_pending_status(fp),
    .fifo_irq_enable(fe), .mod_flags(mf), .mod_enable(me),
    .filter_hit_valid(hv), .filter_hit_index(hi),
    .interrupt_source_code(code), .matched_filter_index(filt), .irq(irq));
initial forever #4 sys_clk = ~sys_clk;
task automatic chk(logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
        $display("ERROR %0t got %h exp %h", $time, s, e);
        n_mismatch++;
    end
endtask
task give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge sys_clk) req <= '{a, v, 1'h1, 1'h0};
    @(posedge sys_clk) req.wr <= 1'h0;
endtask
task automatic rd(logic [3:0] a);
    @(posedge sys_clk) req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge sys_clk) req.rd <= 1'h0;
    #1 d = rdata;
endtask
task automatic put(logic [31:0] f, g, module_flags_t m, n);
    @(posedge sys_clk);
    fp <= f;
    fe <= g;
    mf <= m;
    me <= n;
    repeat (2) @(posedge sys_clk);
    #1;
endtask
task automatic hit(logic [4:0] v);
    @(posedge sys_clk);
    hv <= 1'h1;
    hi <= v;
    @(posedge sys_clk) hv <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
endtask
task t_reset;
    rd(OFF_CODE);
    chk(d, 32'h40);
    wr(OFF_CODE, '1);
    rd(OFF_CODE);
    chk(d, 32'h40);
    rd(4'hC);
    chk(d, 32'h0);
endtask
task t_fifo;
    for (int i = 0; i < 32; i++) begin
        put(32'h1 << i, 32'h1 << i, '0, '0);
        chk(code, i);
    end
endtask
task t_mod;
    for (int k = 0; k < 8; k++) begin
        put('0, '0, 8'h1 << k, '1);
        chk(code, CODE_BUS_ERR + k);
    end
endtask
task t_prio;
    put(32'h20, 32'h20, 8'h81, '1);
    chk(code, 32'h5);
    put('0, 32'h20, 8'h81, '1);
    chk(code, 32'h41);
    put('1, '0, 8'h81, 8'h80);
    chk(code, 32'h48);
    put('1, '0, '1, '0);
    chk(code, 32'h40);
endtask
task t_irq;
    wr(OFF_MASK, 32'h2);
    rd(OFF_MASK);
    chk(d, 32'h2);
    rd(OFF_STATUS);
    hit(5'h1F);
    chk(filt, 32'h1F);
    chk(irq, 32'h1);
    rd(OFF_CODE);
    chk(d, 32'h1F40);
    rd(OFF_STATUS);
    chk(d, 32'h2);
    @(posedge sys_clk);
    #1 chk(irq, 32'h0);
    wr(OFF_MASK, 32'h0);
    hit(5'h00);
    chk(irq, 32'h0);
    chk(filt, 32'h0);
endtask
initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_reset;
    t_fifo;
    t_mod;
    t_prio;
    t_irq;
    give_verdict;
end
initial begin
    #20000;
    n_mismatch++;
    give_verdict;
end
endmodule
bind can_interrupt_code_encoder irq_code_chk #(.FIFOS(FIFOS)) u_chk (.*);
